// >>> dv/att_req_model.sv
// Purpose: Bus requesters on the AGP side, master and host bridge
// Assumes: Requests are levels, changed just after the rising edge
// Notes: Bench picks who wants the bus; model holds it until told otherwise
`timescale 1ns/1ns
module att_req_model (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic want_m,
  input wire logic want_h,
  output logic master_req,
  output logic host_req
);
  // Both agents request alike so the slice is shared fairly
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      master_req <= 1'b0;
      host_req <= 1'b0;
    end else begin
      master_req <= want_m;
      host_req <= want_h;
    end
  end
endmodule : att_req_model

// >>> dv/testbench.sv
// Purpose: Self-checking bench for the aperture and slice timer block
// Assumes: APB master, one wait state answered by pready
// Notes: Timer counts pclk ticks
`timescale 1ns/1ns
module testbench;
  import att_pkg::*;
  logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, tlb_fill = 0, want_m = 0, want_h = 0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, prdata, xlate_fetch_addr, rd;
  logic [9:0] xlate_index = 10'h0;
  logic [2:0] tlb_fill_slot = 3'h0;
  logic [7:0] tlb_valid;
  logic [1:0] bus_grant;
  logic pready, pslverr, master_req, host_req, slice_active, er;
  int errors = 0, total_checks = 0, cyc = 0, n;
  att_regs att_regs_i (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .master_req(master_req), .host_req(host_req), .xlate_index(xlate_index), .tlb_fill(tlb_fill),
    .tlb_fill_slot(tlb_fill_slot), .xlate_fetch_addr(xlate_fetch_addr), .tlb_valid(tlb_valid),
    .bus_grant(bus_grant), .slice_active(slice_active));
  att_req_model att_req_model_i (.pclk(pclk), .presetn(presetn), .want_m(want_m), .want_h(want_h),
    .master_req(master_req), .host_req(host_req));
  always #4 pclk = ~pclk;
  ////////////////////////////////////////
  // Watchdog on total run length
  always @(posedge pclk) begin
    cyc++;
    if (cyc == 20000) begin
      errors++;
      close_out();
    end
  end
  task automatic close_out();
    $display("checks %0d errors %0d", total_checks, errors);
    if (errors == 0 && total_checks > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask : close_out
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    total_checks++;
    if (g !== e) begin
      $display("MISMATCH %s exp %h got %h", nm, e, g);
      errors++;
    end
  endtask : chk
  // One APB transfer, held until pready
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int k;
    k = 0;
    psel <= 1'b1; pwrite <= w; paddr <= a; pwdata <= d;
    @(posedge pclk); penable <= 1'b1;
    do begin @(posedge pclk); k++; end while (pready !== 1'b1 && k < 20);
    if (pready !== 1'b1) begin
      $display("MISMATCH pready exp 1 got %b", pready);
      errors++;
    end
    rd = prdata; er = pslverr;
    psel <= 1'b0; penable <= 1'b0;
    @(posedge pclk);
  endtask : apb
  ////////////////////////////////////////
  // Register reset values and masking
  task automatic t_regs();
    apb(0, ATT_OFF_SIZE, 0); chk("size rst", 0, rd);
    apb(0, ATT_OFF_MTT, 0); chk("mtt rst", 0, rd);
    apb(1, ATT_OFF_APB, 32'hFFFFFFFF); apb(0, ATT_OFF_APB, 0); chk("apb 256M", 0, rd);
    apb(1, ATT_OFF_SIZE, 32'h38); apb(1, ATT_OFF_APB, 32'hFFFFFFFF);
    apb(0, ATT_OFF_APB, 0); chk("apb 32M", 32'h0E000000, rd);
    apb(0, 8'hD0, 0); chk("unmapped err", 1, er);
    chk("unmapped data", 0, rd);
    apb(1, ATT_OFF_STAT, 0); chk("status wr err", 1, er);
    apb(1, ATT_OFF_MTT, 32'hFF); apb(0, ATT_OFF_MTT, 0); chk("mtt mask", 32'hF8, rd);
  endtask : t_regs
  // Table pointer and lookaside buffer
  task automatic t_xlate();
    apb(1, ATT_OFF_TTB, 32'h12345FFF); apb(0, ATT_OFF_TTB, 0); chk("ttb", 32'h12345000, rd);
    xlate_index <= 10'h3FF; repeat (3) @(posedge pclk);
    chk("fetch", 32'h12345FFC, xlate_fetch_addr);
    apb(1, ATT_OFF_CTRL, 32'h80); tlb_fill <= 1; tlb_fill_slot <= 3'h3;
    @(posedge pclk); tlb_fill <= 0; repeat (2) @(posedge pclk);
    chk("fill", 8'h08, tlb_valid);
    apb(1, ATT_OFF_CTRL, 0); repeat (2) @(posedge pclk); chk("flush", 0, tlb_valid);
    apb(1, ATT_OFF_TTB, 32'h00ABC000); repeat (3) @(posedge pclk); chk("fetch2", 32'h00ABCFFC, xlate_fetch_addr);
  endtask : t_xlate
  // Slice length with both sides requesting
  task automatic t_slice();
    apb(1, ATT_OFF_MTT, 32'h18); want_m <= 1; want_h <= 1;
    n = 0;
    while (bus_grant !== ATT_OWN_HOST && n < 20) begin @(posedge pclk); n++; end
    chk("to host", ATT_OWN_HOST, bus_grant);
    n = 0;
    @(posedge pclk); chk("active", 1, slice_active);
    while (bus_grant !== ATT_OWN_MASTER && n < 60) begin @(posedge pclk); n++; end
    chk("slice", 1, n >= 23 && n <= 25);
    apb(1, ATT_OFF_MTT, 0); rd = bus_grant; repeat (3) @(posedge pclk);
    chk("no slice", 1, bus_grant !== rd[1:0]);
    want_m <= 0; want_h <= 0;
  endtask : t_slice
  initial begin
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    chk("grant rst", ATT_OWN_MASTER, bus_grant);
    t_regs();
    t_xlate();
    t_slice();
    close_out();
  end
endmodule : testbench

// >>> hw/att_pkg.sv
// Purpose: Constants for aperture translation and AGP slice timer
// Assumes: APB, 32-bit data, byte addresses
// Notes: Offsets of size/base/control registers are local choices
package att_pkg;
  localparam logic [7:0] ATT_OFF_CTRL = 8'hB0;
  localparam logic [7:0] ATT_OFF_SIZE = 8'hB4;
  localparam logic [7:0] ATT_OFF_TTB = 8'hB8;
  localparam logic [7:0] ATT_OFF_MTT = 8'hBC;
  localparam logic [7:0] ATT_OFF_APB = 8'hC0;
  localparam logic [7:0] ATT_OFF_STAT = 8'hC8;
  localparam int ATT_CTRL_EN_BIT = 7;
  localparam int ATT_TTB_LSB = 12;
  localparam int ATT_APB_LSB = 22;
  localparam int ATT_APB_MSB = 27;
  localparam int ATT_MTT_LSB = 3;
  localparam int ATT_TLB_N = 8;
  localparam logic [5:0] ATT_SIZE_RST = 6'h00;
  localparam logic [19:0] ATT_TTB_RST = 20'h00000;
  localparam logic [4:0] ATT_MTT_RST = 5'h00;
  localparam logic [31:0] ATT_ERR_DATA = 32'h00000000;
  typedef enum logic [1:0] {
    ATT_OWN_MASTER = 2'b01,
    ATT_OWN_HOST = 2'b10
  } att_owner_t;
endpackage : att_pkg

// >>> hw/att_regs.sv
// Purpose: Aperture size/base, translation table base, lookaside control and AGP slice timer
// Assumes: APB slave, single clock pclk, presetn asynchronous active low
// Notes: Timer counts pclk as the AGP clock tick
// Notes: Status word is read-only; a write to it answers with an error
// Notes: Aperture base is stored already masked, so widening the mask shows zeros
// Notes: Every access takes one wait state; ready and data stand for one cycle
//
// Overview of operation
// R1: Size mask bit zero forces matching aperture base bit 27:22 to zero.
// R2: Software writes only contiguous top-down mask patterns, 4 MB to 256 MB.
// R3: Size mask resets to zero, giving fixed-zero base bits and 256 MB.
// R4: Table base holds pointer in bits 31:12; bits 11:0 read zero.
// R5: Table pointer is a 4-kB aligned address, low twelve bits zero.
// R6: Translation logic fetches entries from table pointer plus entry index.
// R7: Table pointer writes accepted at any time.
// R8: Software should change table pointer only while lookaside buffer disabled.
// R9: Lookaside enable zero clears the valid bit of every entry.
// R10: Owner keeps bus for programmed slice; grant moves only after expiry. The code also hands over early when the owner drops its request.
// R11: Slice applies equally to AGP master and host bridge.
// R12: Timer resets to 00h; zero disables the slice mechanism.
// R13: Count in bits 7:3, steps of eight clocks; bits 2:0 read zero.
// R14: Slice counter reloads on ownership change, decrements each clock.
//
// Local design decision: the APB slave port.
`timescale 1ns/1ns
module att_regs
  import att_pkg::*;
(
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // Register bus
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Requests from the two bus agents
  input wire logic master_req,
  input wire logic host_req,
  // Translation and lookaside side
  input wire logic [9:0] xlate_index,
  input wire logic tlb_fill,
  input wire logic [2:0] tlb_fill_slot,
  output logic [31:0] xlate_fetch_addr,
  output logic [ATT_TLB_N-1:0] tlb_valid,
  // Arbiter state
  output logic [1:0] bus_grant,
  output logic slice_active
);

  typedef struct packed {
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic [5:0] aperture_size_mask;
    logic [5:0] aperture_base_address;
    logic [19:0] table_pointer_field;
    logic [4:0] slice_count_value;
    logic tlb_enable;
    logic [ATT_TLB_N-1:0] valid;
    logic [31:0] fetch_addr;
    att_owner_t owner;
    logic [7:0] slice_cnt;
    logic slice_active;
  } att_state_t;

  att_state_t st_r;
  att_state_t st_nxt;

  // Decoded strobes and arbiter terms
  logic wr_en;
  logic rd_en;
  logic other_req;
  logic own_req;
  logic slice_done;
  logic [7:0] slice_len;

  ////////////////////////////////////////////////////////////////////////
  // Bus decode
  assign wr_en = psel && penable && pwrite && !st_r.pready;
  assign rd_en = psel && penable && !pwrite && !st_r.pready;
  // Slice length in clocks equals the register value itself
  assign slice_len = {st_r.slice_count_value, 3'b000}; // [R13]
  // Current owner and the waiting agent, same treatment for both
  assign own_req = (st_r.owner == ATT_OWN_MASTER) ? master_req : host_req;
  assign other_req = (st_r.owner == ATT_OWN_MASTER) ? host_req : master_req; // [R11]
  // Slice spent
  assign slice_done = (st_r.slice_cnt == 8'h00);

  ////////////////////////////////////////////////////////////////////////
  // Next state
  always_comb begin
    // Default: hold all state, bus answer idle
    st_nxt = st_r;
    st_nxt.pready = 1'b0;
    st_nxt.pslverr = 1'b0;
    st_nxt.prdata = ATT_ERR_DATA;
    if (wr_en) begin
      // Write lands with the ready pulse
      st_nxt.pready = 1'b1;
      case (paddr)
        ATT_OFF_CTRL: begin
          // Lookaside enable, flushes while zero
          st_nxt.tlb_enable = pwdata[ATT_CTRL_EN_BIT];
        end
        ATT_OFF_SIZE: begin
          // Mask stored as written, no contiguity check
          st_nxt.aperture_size_mask = pwdata[5:0]; // [R2]
        end
        ATT_OFF_TTB: begin
          // Pointer may change at any time
          st_nxt.table_pointer_field = pwdata[31:ATT_TTB_LSB]; // [R7]
        end
        ATT_OFF_MTT: begin
          // Only the count bits are kept
          st_nxt.slice_count_value = pwdata[7:ATT_MTT_LSB]; // [R13]
        end
        ATT_OFF_APB: begin
          // Masked further down in this process
          st_nxt.aperture_base_address = pwdata[ATT_APB_MSB:ATT_APB_LSB];
        end
        ATT_OFF_STAT: begin
          // Status is read-only
          st_nxt.pslverr = 1'b1;
        end
        default: begin
          // No register here
          st_nxt.pslverr = 1'b1;
        end
      endcase
    end else if (rd_en) begin
      // Read answer, reserved bits zero
      st_nxt.pready = 1'b1;
      case (paddr)
        ATT_OFF_CTRL: begin
          // Enable sits in bit 7
          st_nxt.prdata = {24'h000000, st_r.tlb_enable, 7'h00};
        end
        ATT_OFF_SIZE: begin
          // Six mask bits
          st_nxt.prdata = {26'h0000000, st_r.aperture_size_mask};
        end
        ATT_OFF_TTB: begin
          // Pointer with low twelve bits zero
          st_nxt.prdata = {st_r.table_pointer_field, 12'h000}; // [R4]
        end
        ATT_OFF_MTT: begin
          // Count bits, low three zero
          st_nxt.prdata = {24'h000000, slice_len}; // [R13]
        end
        ATT_OFF_APB: begin
          // Masked base bits read as zero
          st_nxt.prdata = {4'h0, st_r.aperture_base_address & st_r.aperture_size_mask,
                           22'h000000}; // [R1]
        end
        ATT_OFF_STAT: begin
          // Owner and live slice counter
          st_nxt.prdata = {22'h000000, st_r.owner, st_r.slice_cnt};
        end
        default: begin
          // No register here
          st_nxt.pslverr = 1'b1;
        end
      endcase
    end
    // Base bits under a zero mask bit are held at zero
    st_nxt.aperture_base_address = st_nxt.aperture_base_address & st_nxt.aperture_size_mask; // [R1]
    // Lookaside valid bits: fill when enabled, flush when disabled
    if (!st_r.tlb_enable) begin
      st_nxt.valid = '0; // [R9]
    end else if (tlb_fill) begin
      st_nxt.valid[tlb_fill_slot] = 1'b1;
    end
    // Entry fetch address from aligned table base
    st_nxt.fetch_addr = {st_r.table_pointer_field, 12'h000} + {20'h00000, xlate_index, 2'b00}; // [R5] [R6]
    // Arbiter: keep owner until slice expires or owner idles
    if (st_r.slice_cnt != 8'h00) begin
      st_nxt.slice_cnt = st_r.slice_cnt - 8'h01; // [R14]
    end
    if (other_req && (slice_len == 8'h00 || slice_done || !own_req)) begin // [R10] [R12]
      case (st_r.owner)
        ATT_OWN_MASTER: st_nxt.owner = ATT_OWN_HOST;
        ATT_OWN_HOST: st_nxt.owner = ATT_OWN_MASTER;
        default: st_nxt.owner = ATT_OWN_MASTER;
      endcase
      // New owner gets a full slice
      st_nxt.slice_cnt = slice_len; // [R14]
    end
    // Registered flag so the output comes from a flip-flop
    st_nxt.slice_active = (st_nxt.slice_cnt != 8'h00);
  end

  ////////////////////////////////////////////////////////////////////////
  // State register
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      // Everything cleared, master owns the bus
      st_r <= '0;
      st_r.aperture_size_mask <= ATT_SIZE_RST; // [R3]
      st_r.table_pointer_field <= ATT_TTB_RST;
      st_r.slice_count_value <= ATT_MTT_RST; // [R12]
      st_r.owner <= ATT_OWN_MASTER;
    end else begin
      st_r <= st_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Outputs
  assign prdata = st_r.prdata;
  assign pready = st_r.pready;
  assign pslverr = st_r.pslverr;
  assign xlate_fetch_addr = st_r.fetch_addr;
  assign tlb_valid = st_r.valid;
  assign bus_grant = st_r.owner;
  assign slice_active = st_r.slice_active;

  ////////////////////////////////////////////////////////////////////////
  // Checks
  // Stored base never holds a bit under a zero mask bit
  base_mask_a: assert property (@(posedge pclk) disable iff (!presetn) // [R1]
    (st_r.aperture_base_address & ~st_r.aperture_size_mask) == 6'h00)
    else $error("base bit set under zero mask");

  // Table base read shows zero low bits
  ttb_low_zero_a: assert property (@(posedge pclk) disable iff (!presetn) // [R4]
    (st_r.pready && $past(rd_en) && $past(paddr) == ATT_OFF_TTB) |-> prdata[11:0] == 12'h000)
    else $error("table base low bits not zero");

  // Fetch address follows pointer and index of the cycle before
  fetch_align_a: assert property (@(posedge pclk) disable iff (!presetn) // [R6]
    $stable(st_r.table_pointer_field) && $stable(xlate_index) |=>
    xlate_fetch_addr == {$past(st_r.table_pointer_field), 12'h000} + {20'h00000, $past(xlate_index), 2'b00})
    else $error("fetch address wrong");

  // Pointer write lands one cycle later
  ttb_write_a: assert property (@(posedge pclk) disable iff (!presetn) // [R7]
    (wr_en && paddr == ATT_OFF_TTB) |=> st_r.table_pointer_field == $past(pwdata[31:12]))
    else $error("table base write lost");

  // Disabled lookaside holds no valid entry
  tlb_flush_a: assert property (@(posedge pclk) disable iff (!presetn) // [R9]
    !st_r.tlb_enable |=> tlb_valid == '0)
    else $error("lookaside not flushed");

  // Owner keeps the bus during its slice
  slice_hold_a: assert property (@(posedge pclk) disable iff (!presetn) // [R10]
    (st_r.slice_cnt != 8'h00 && own_req && slice_len != 8'h00) |=> $stable(bus_grant))
    else $error("grant moved during slice");

  // Handover loads a full slice
  slice_reload_a: assert property (@(posedge pclk) disable iff (!presetn) // [R14]
    $changed(bus_grant) |-> st_r.slice_cnt == $past(slice_len))
    else $error("slice not reloaded");

  // Zero timer hands over at once
  zero_disable_a: assert property (@(posedge pclk) disable iff (!presetn) // [R12]
    (slice_len == 8'h00 && other_req) |=> $changed(bus_grant))
    else $error("zero timer did not disable slice");

  // Timer read shows zero low bits
  mtt_read_a: assert property (@(posedge pclk) disable iff (!presetn) // [R13]
    (st_r.pready && $past(rd_en) && $past(paddr) == ATT_OFF_MTT) |-> prdata[2:0] == 3'b000)
    else $error("timer low bits not zero");

  // Timer write keeps only the count bits
  mtt_write_a: assert property (@(posedge pclk) disable iff (!presetn) // [R13]
    (wr_en && paddr == ATT_OFF_MTT) |=> st_r.slice_count_value == $past(pwdata[7:3]))
    else $error("timer write lost");

  // Size mask write lands one cycle later
  size_write_a: assert property (@(posedge pclk) disable iff (!presetn) // [R1]
    (wr_en && paddr == ATT_OFF_SIZE) |=> st_r.aperture_size_mask == $past(pwdata[5:0]))
    else $error("size mask write lost");

  // Base read shows only bits 27:22
  base_read_a: assert property (@(posedge pclk) disable iff (!presetn) // [R1]
    (st_r.pready && $past(rd_en) && $past(paddr) == ATT_OFF_APB) |->
    (prdata[31:28] == 4'h0 && prdata[21:0] == 22'h000000))
    else $error("base read outside field");

  // Exactly one agent owns the bus
  grant_onehot_a: assert property (@(posedge pclk) disable iff (!presetn) // [R11]
    bus_grant == ATT_OWN_MASTER || bus_grant == ATT_OWN_HOST)
    else $error("grant not one owner");

  // Counter steps down by one while nobody waits
  count_down_a: assert property (@(posedge pclk) disable iff (!presetn) // [R14]
    (st_r.slice_cnt != 8'h00 && !other_req) |=> st_r.slice_cnt == $past(st_r.slice_cnt) - 8'h01)
    else $error("slice counter did not step");

  // Active flag matches the live counter
  active_flag_a: assert property (@(posedge pclk) disable iff (!presetn) // [R14]
    slice_active == (st_r.slice_cnt != 8'h00))
    else $error("slice flag wrong");

  // Ready is a single-cycle pulse
  ready_pulse_a: assert property (@(posedge pclk) disable iff (!presetn)
    pready |=> !pready)
    else $error("ready held too long");

  // Error only comes with ready
  err_ready_a: assert property (@(posedge pclk) disable iff (!presetn)
    pslverr |-> pready)
    else $error("error without ready");

endmodule : att_regs
